/* File: design/ulms_pkg.sv */
// Constants, field layout and carrier types for the UART line/modem status block.
// Assumes one clock domain and a host on the same clock.
package ulms_pkg;
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IID  = 3'h2;
    localparam logic [2:0] ADDR_LCTL = 3'h3;
    localparam logic [2:0] ADDR_MCTL = 3'h4;
    localparam logic [2:0] ADDR_LSR  = 3'h5;
    localparam logic [2:0] ADDR_MSR  = 3'h6;
    localparam logic [2:0] ADDR_SCR  = 3'h7;
    // Line control fields
    localparam int LC_WL    = 0;
    localparam int LC_STOP  = 2;
    localparam int LC_PEN   = 3;
    localparam int LC_EVEN  = 4;
    localparam int LC_STICK = 5;
    localparam int LC_BREAK = 6;
    // Modem control fields
    localparam int MC_DTR  = 0;
    localparam int MC_RTS  = 1;
    localparam int MC_OUT1 = 2;
    localparam int MC_OUT2 = 3;
    localparam int MC_LOOP = 4;
    localparam logic [7:0] LCTL_RST = 8'h00;
    localparam logic [4:0] MCTL_RST = 5'h00;
    localparam logic [7:0] SCR_RST  = 8'h00;
    localparam int BIT_CYCLES_DEF = 16;
    // Modem levels, laid out as modem status bits 7..4
    typedef struct packed {
        logic carrier;
        logic bell;
        logic set_ready;
        logic clear_send;
    } ulms_modem_t;
    typedef struct packed {
        logic modem;
        logic thr;
        logic line;
        logic rx;
    } ulms_irq_t;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_DATA  = 5'h04,
        ST_PAR   = 5'h08,
        ST_STOP  = 5'h10
    } ulms_state_t;
endpackage

/* File: design/ulms_core.sv */
// UART status core: receiver, transmitter, line and modem status, scratchpad.
// Assumes host strobes are one-cycle pulses on the same clock; pins are asynchronous.
`timescale 1ns/1ps
module ulms_core #(
    parameter int BIT_CYCLES = ulms_pkg::BIT_CYCLES_DEF
) (
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    input  wire logic [2:0]          host_addr,
    input  wire logic                addr_strobe_n,
    input  wire logic                host_rd,
    input  wire logic                host_wr,
    input  wire logic [7:0]          host_write_bus,
    output logic      [7:0]          host_read_bus,
    input  wire logic                serial_input,
    output logic                     serial_output,
    input  wire ulms_pkg::ulms_modem_t modem_in_n,
    output logic                     term_ready_out_n,
    output logic                     req_send_out_n,
    output logic                     aux1_out_n,
    output logic                     aux2_out_n,
    output ulms_pkg::ulms_irq_t      irq
);
    import ulms_pkg::*;
    localparam logic [15:0] BIT_M1  = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_M1 = 16'(BIT_CYCLES / 2 - 1);
    localparam logic [15:0] ST15_M1 = 16'(BIT_CYCLES * 3 / 2 - 1);
    localparam logic [15:0] ST2_M1  = 16'(BIT_CYCLES * 2 - 1);

    logic [2:0]  addr_reg;
    logic [7:0]  lctl_reg, scr_reg, rbuf_reg, thr_reg, rx_sh, tx_sh;
    logic [4:0]  mctl_reg;
    logic [4:0]  sync1_reg, sync2_reg;
    logic        rdr_reg, ovr_reg, par_reg, frm_reg, brk_reg, thre_reg, thr_full;
    logic [3:0]  delta_reg;
    ulms_modem_t lev_prev;
    ulms_state_t rx_st, tx_st;
    logic [15:0] rx_cnt, tx_cnt, low_cnt;
    logic [3:0]  rx_bitn, tx_bitn;
    logic        rx_par, rx_perr, tx_par;

    // Access decode on the captured address
    wire rd_rbr  = host_rd && addr_reg == ADDR_DATA;
    wire rd_iid  = host_rd && addr_reg == ADDR_IID;
    wire rd_lsr  = host_rd && addr_reg == ADDR_LSR;
    wire rd_msr  = host_rd && addr_reg == ADDR_MSR;
    wire wr_thr  = host_wr && addr_reg == ADDR_DATA;
    wire wr_lctl = host_wr && addr_reg == ADDR_LCTL;
    wire wr_mctl = host_wr && addr_reg == ADDR_MCTL;
    wire wr_scr  = host_wr && addr_reg == ADDR_SCR;

    // Loopback from modem control, frame shape from line control
    wire       loop    = mctl_reg[MC_LOOP];
    wire       pen     = lctl_reg[LC_PEN];
    wire       even    = lctl_reg[LC_EVEN];
    wire       stick   = lctl_reg[LC_STICK];
    wire [3:0] wl_len  = 4'h5 + {2'h0, lctl_reg[LC_WL +: 2]};
    wire [3:0] stops   = lctl_reg[LC_STOP] ? 4'h2 : 4'h1;
    wire [3:0] frame_b = 4'h1 + wl_len + {3'h0, pen} + stops;
    wire [15:0] brk_lim = 16'(frame_b * BIT_CYCLES);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sync1_reg <= 5'h1f;
            sync2_reg <= 5'h1f;
        end else if (clk_en) begin
            sync1_reg <= {serial_input, modem_in_n};
            sync2_reg <= sync1_reg;
        end
    end

    // Transmit bit on the wire before loopback and break forcing
    logic tx_bit;
    always_comb begin
        case (tx_st)
            ST_START: tx_bit = 1'b0;
            ST_DATA:  tx_bit = tx_sh[0];
            ST_PAR:   tx_bit = tx_par;
            default:  tx_bit = 1'b1;
        endcase
    end
    // Loopback replaces the serial input by the transmit bit and the modem pins by control bits
    wire rx_in = loop ? tx_bit : sync2_reg[4];
    wire ulms_modem_t lev = loop ?
        {mctl_reg[MC_OUT2], mctl_reg[MC_OUT1], mctl_reg[MC_DTR], mctl_reg[MC_RTS]} : ~sync2_reg[3:0];

    // Receiver events
    wire rx_tick   = rx_cnt == 16'h0000;
    wire rx_store  = rx_st == ST_STOP && rx_tick;
    wire rx_exp    = stick ? ~even : (rx_par ^ ~even);
    wire [7:0] rx_word = rx_sh >> (4'h8 - wl_len);
    wire brk_set   = !rx_in && low_cnt == brk_lim;
    wire ovr_set   = rx_store && rdr_reg;
    wire par_set   = rx_store && rx_perr;
    // Only the first stop bit is judged
    wire frm_set   = rx_store && !rx_in;

    // Receiver machine, samples mid-bit
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rx_st   <= ST_IDLE;
            rx_cnt  <= 16'h0000;
            rx_bitn <= 4'h0;
            rx_sh   <= 8'h00;
            rx_par  <= 1'b0;
            rx_perr <= 1'b0;
        end else if (clk_en) begin
            rx_cnt <= rx_tick ? BIT_M1 : rx_cnt - 16'h0001;
            case (rx_st)
                ST_IDLE: begin
                    rx_cnt <= HALF_M1;
                    if (!rx_in) begin
                        rx_st <= ST_START;
                    end
                end
                ST_START: if (rx_tick) begin
                    rx_st   <= rx_in ? ST_IDLE : ST_DATA;
                    rx_bitn <= 4'h0;
                    rx_par  <= 1'b0;
                    rx_perr <= 1'b0;
                end
                ST_DATA: if (rx_tick) begin
                    rx_sh   <= {rx_in, rx_sh[7:1]};
                    rx_par  <= rx_par ^ rx_in;
                    rx_bitn <= rx_bitn + 4'h1;
                    if (rx_bitn == wl_len - 4'h1) begin
                        rx_st <= pen ? ST_PAR : ST_STOP;
                    end
                end
                ST_PAR: if (rx_tick) begin
                    rx_perr <= rx_in != rx_exp;
                    rx_st   <= ST_STOP;
                end
                ST_STOP: if (rx_tick) begin
                    rx_st <= ST_IDLE;
                end
                default: rx_st <= ST_IDLE;
            endcase
        end
    end

    // Break timer saturates one past the limit so the flag sets once per break
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            low_cnt <= 16'h0000;
        end else if (clk_en) begin
            if (rx_in) begin
                low_cnt <= 16'h0000;
            end else if (low_cnt <= brk_lim) begin
                low_cnt <= low_cnt + 16'h0001;
            end
        end
    end

    // Transmitter events
    wire tx_tick = tx_cnt == 16'h0000;
    wire tx_xfer = tx_st == ST_IDLE && thr_full;
    wire [15:0] stop_m1 = !lctl_reg[LC_STOP] ? BIT_M1 : (wl_len == 4'h5 ? ST15_M1 : ST2_M1);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tx_st   <= ST_IDLE;
            tx_cnt  <= 16'h0000;
            tx_bitn <= 4'h0;
            tx_sh   <= 8'h00;
            tx_par  <= 1'b0;
        end else if (clk_en) begin
            tx_cnt <= tx_cnt - 16'h0001;
            case (tx_st)
                ST_IDLE: if (thr_full) begin
                    tx_st   <= ST_START;
                    tx_sh   <= thr_reg;
                    tx_cnt  <= BIT_M1;
                    tx_bitn <= 4'h0;
                end
                ST_START: if (tx_tick) begin
                    tx_st  <= ST_DATA;
                    tx_cnt <= BIT_M1;
                    tx_par <= stick ? ~even : ~even ^ (^(tx_sh & (8'hff >> (4'h8 - wl_len))));
                end
                ST_DATA: if (tx_tick) begin
                    tx_sh   <= {1'b0, tx_sh[7:1]};
                    tx_bitn <= tx_bitn + 4'h1;
                    tx_cnt  <= BIT_M1;
                    if (tx_bitn == wl_len - 4'h1) begin
                        tx_st  <= pen ? ST_PAR : ST_STOP;
                        tx_cnt <= pen ? BIT_M1 : stop_m1;
                    end
                end
                ST_PAR: if (tx_tick) begin
                    tx_st  <= ST_STOP;
                    tx_cnt <= stop_m1;
                end
                ST_STOP: if (tx_tick) begin
                    tx_st <= ST_IDLE;
                end
                default: tx_st <= ST_IDLE;
            endcase
        end
    end

    // Next values of the status flags; a set in the clearing cycle wins, except holding empty, which a write clears
    // Data ready
    wire rdr_next  = rx_store || (rdr_reg && !rd_rbr);
    // Error flags clear on line status read
    wire ovr_next  = ovr_set || (ovr_reg && !rd_lsr);
    wire par_next  = par_set || (par_reg && !rd_lsr);
    wire frm_next  = frm_set || (frm_reg && !rd_lsr);
    wire brk_next  = brk_set || (brk_reg && !rd_lsr);
    // Holding empty; a write in the transfer cycle refills it
    wire thre_next = (tx_xfer && !wr_thr) || (thre_reg && !wr_thr && !rd_iid);
    wire full_next = wr_thr || (thr_full && !tx_xfer);
    wire ulms_modem_t chg = lev ^ lev_prev;
    wire [3:0] dset = {chg.carrier, lev_prev.bell && !lev.bell, chg.set_ready, chg.clear_send};
    wire [3:0] delta_next = dset | (delta_reg & {4{!rd_msr}});
    wire tre = !thr_full && tx_st == ST_IDLE;
    wire [7:0] lsr_val = {1'b0, tre, thre_reg, brk_reg, frm_reg, par_reg, ovr_reg, rdr_reg};
    wire [7:0] msr_val = {lev, delta_reg};
    wire ulms_irq_t irq_next = '{modem: |delta_reg, thr: thre_reg,
                                  line: ovr_reg | par_reg | frm_reg | brk_reg, rx: rdr_reg};

    // Output mux; unmapped reads give zero
    logic [7:0] rd_mux;
    always_comb begin
        case (addr_reg)
            ADDR_DATA: rd_mux = rbuf_reg;
            ADDR_IID:  rd_mux = {7'h00, ~|irq_next};
            ADDR_LCTL: rd_mux = lctl_reg;
            ADDR_MCTL: rd_mux = {3'h0, mctl_reg};
            ADDR_LSR:  rd_mux = lsr_val;
            ADDR_MSR:  rd_mux = msr_val;
            ADDR_SCR:  rd_mux = scr_reg;
            default:   rd_mux = 8'h00;
        endcase
    end

    // Address flops enabled by the strobe
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            addr_reg <= 3'h0;
        end else if (clk_en && !addr_strobe_n) begin
            addr_reg <= host_addr;
        end
    end

    // Host registers and status flags
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            lctl_reg <= LCTL_RST;
            mctl_reg <= MCTL_RST;
            scr_reg  <= SCR_RST;
            thr_reg  <= 8'h00;
            rbuf_reg <= 8'h00;
            {rdr_reg, ovr_reg, par_reg, frm_reg, brk_reg} <= 5'h00;
            thre_reg <= 1'b1;
            thr_full <= 1'b0;
            delta_reg <= 4'h0;
            lev_prev <= '0;
        end else if (clk_en) begin
            if (wr_lctl) lctl_reg <= host_write_bus;
            if (wr_mctl) mctl_reg <= host_write_bus[4:0];
            if (wr_scr) scr_reg <= host_write_bus;
            if (wr_thr) thr_reg <= host_write_bus;
            if (rx_store) rbuf_reg <= rx_word;
            {rdr_reg, ovr_reg, par_reg, frm_reg, brk_reg} <= {rdr_next, ovr_next, par_next, frm_next, brk_next};
            thre_reg  <= thre_next;
            thr_full  <= full_next;
            delta_reg <= delta_next;
            lev_prev  <= lev;
        end
    end

    // Registered outputs; the read bus follows the mux one cycle later, gated only by the clock enable
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            host_read_bus <= 8'h00;
            serial_output <= 1'b1;
            {term_ready_out_n, req_send_out_n, aux1_out_n, aux2_out_n} <= 4'hf;
            irq <= '0;
        end else if (clk_en) begin
            host_read_bus <= rd_mux;
            serial_output <= loop || (!lctl_reg[LC_BREAK] && tx_bit);
            // Loopback keeps the modem outputs inactive
            term_ready_out_n <= loop || !mctl_reg[MC_DTR];
            req_send_out_n   <= loop || !mctl_reg[MC_RTS];
            aux1_out_n       <= loop || !mctl_reg[MC_OUT1];
            aux2_out_n       <= loop || !mctl_reg[MC_OUT2];
            irq <= irq_next;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    rx_ready_set_a: assert property (clk_en && rx_store |=> rdr_reg && irq_next.rx)
        else $error("data ready not set on store");
    overrun_set_a: assert property (clk_en && rx_store && rdr_reg |=> ovr_reg)
        else $error("overrun not flagged");
    lsr_read_clear_a: assert property (clk_en && rd_lsr && !brk_set && !rx_store |=> lsr_val[4:1] == 4'h0)
        else $error("error flags survive line status read");
    lsr_bit7_a: assert property (clk_en && addr_reg == ADDR_LSR |=> host_read_bus[7] == 1'b0)
        else $error("line status bit 7 not zero");
    thr_write_a: assert property (clk_en && wr_thr |=> !thre_reg && !tre)
        else $error("holding empty or tx empty after write");
    modem_change_a: assert property (clk_en && lev.clear_send != lev_prev.clear_send |=> delta_reg[0])
        else $error("clear send change missed");
    bell_edge_a: assert property (clk_en && lev_prev.bell && !lev.bell |=> delta_reg[2] && irq_next.modem)
        else $error("bell trailing edge missed");
    scratch_hold_a: assert property (clk_en && wr_scr |=> scr_reg == $past(host_write_bus))
        else $error("scratchpad write lost");
    start_bit_a: assert property (clk_en && tx_xfer && !loop && !lctl_reg[LC_BREAK] |=> ##1 !serial_output)
        else $error("start bit not driven low");
endmodule

/* File: tb/ulms_peer.sv */
// Serial far end: sends raw frames into the receiver and samples frames from the transmitter.
// Assumes an idle-high line, LSB first, BIT_CYCLES clocks per bit, one frame in flight at a time.
`timescale 1ns/1ps
module ulms_peer #(
    parameter int BIT_CYCLES = 4
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        frame_go,
    input  wire logic [15:0] frame_bits,
    input  wire logic [4:0]  frame_len,
    input  wire logic [4:0]  cap_len,
    input  wire logic        line_from_dut,
    output logic             line_to_dut,
    output logic      [15:0] cap_frame,
    output logic      [7:0]  cap_count
);
    // frame sender
    // One bit per BIT_CYCLES; the line returns to idle high so no stale low lingers
    initial begin
        line_to_dut = 1'b1;
        forever begin
            @(posedge clock);
            if (frame_go === 1'b1) begin
                for (int i = 0; i < frame_len; i++) begin
                    line_to_dut <= frame_bits[i];
                    repeat (BIT_CYCLES) @(posedge clock);
                end
                line_to_dut <= 1'b1;
            end
        end
    end

    // frame capture
    // Mid-bit sampling after the start edge, just off the clock edge to dodge the output flop
    initial begin
        cap_count = 8'h00;
        cap_frame = 16'hffff;
        @(posedge reset_n);
        forever begin
            @(negedge line_from_dut);
            repeat (BIT_CYCLES / 2) @(posedge clock);
            for (int i = 0; i < cap_len; i++) begin
                #1 cap_frame[i] = line_from_dut;
                repeat (BIT_CYCLES) @(posedge clock);
            end
            cap_count = cap_count + 8'h01;
        end
    end
endmodule

/* File: tb/uart_line_modem_status_tb.sv */
// Self-checking bench for the status core: register bus, receive, transmit, modem and loopback.
// Assumes the serial peer model and a short bit time to keep the run brief.
`timescale 1ns/1ps
module uart_line_modem_status_tb;
    import ulms_pkg::*;
    localparam int BITC = 4;
    logic        clock, reset_n, clk_en, addr_strobe_n, host_rd, host_wr;
    logic [2:0]  host_addr;
    logic [7:0]  host_write_bus, host_read_bus, rd_val, lc, wd, wd2;
    logic        serial_input, serial_output, dtr_n, rts_n, o1_n, o2_n, frame_go;
    ulms_modem_t modem_in_n;
    ulms_irq_t   irq;
    logic [15:0] frame_bits, cap_frame, msk;
    logic [4:0]  frame_len, cap_len;
    logic [7:0]  cap_count, c0;
    logic [3:0]  mv, mo, dl;
    int          failures, checks_done, seed, k;

    // Free-running clock; inputs move on rising edges by non-blocking assignment
    always #2 clock = ~clock;

    ulms_core #(.BIT_CYCLES(BITC)) dut_u (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
        .host_addr(host_addr), .addr_strobe_n(addr_strobe_n), .host_rd(host_rd), .host_wr(host_wr),
        .host_write_bus(host_write_bus), .host_read_bus(host_read_bus), .serial_input(serial_input),
        .serial_output(serial_output), .modem_in_n(modem_in_n), .term_ready_out_n(dtr_n),
        .req_send_out_n(rts_n), .aux1_out_n(o1_n), .aux2_out_n(o2_n), .irq(irq));
    ulms_peer #(.BIT_CYCLES(BITC)) peer_u (.clock(clock), .reset_n(reset_n), .frame_go(frame_go),
        .frame_bits(frame_bits), .frame_len(frame_len), .cap_len(cap_len), .line_from_dut(serial_output),
        .line_to_dut(serial_input), .cap_frame(cap_frame), .cap_count(cap_count));

    // Expected frame: start, data LSB first, parity, stops; unused tail stays high
    function automatic logic [15:0] mkf(logic [7:0] w, logic [7:0] l, logic bp, logic bs);
        logic [15:0] f;
        int          n;
        f = 16'hffff;
        n = 5 + l[1:0];
        f[0] = 1'b0;
        for (int i = 0; i < n; i++) f[1+i] = w[i];
        if (l[3]) f[1+n] = (l[5] ? ~l[4] : (l[4] ? ^(w & 8'((1 << n) - 1)) : ~^(w & 8'((1 << n) - 1)))) ^ bp;
        f[1+n+l[3]] = ~bs;
        return f;
    endfunction
    function automatic logic [4:0] flen(logic [7:0] l);
        return 5'(7 + l[1:0] + l[3] + l[2]);
    endfunction

    task automatic cyc(int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // address strobe first, then the strobe-qualified access one edge later
    task automatic bus(logic [2:0] a, logic wr, logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        addr_strobe_n <= 1'b0;
        host_addr <= a;
        @(posedge clock);
        addr_strobe_n <= 1'b1;
        host_wr <= wr;
        host_rd <= ~wr;
        host_write_bus <= d;
        @(posedge clock);
        host_wr <= 1'b0;
        host_rd <= 1'b0;
        #1 q = host_read_bus;
    endtask
    task automatic rchk(string what, logic [2:0] a, logic [7:0] exp, logic [7:0] m);
        bus(a, 1'b0, 8'h00, rd_val);
        chk(what, {8'h00, exp}, {8'h00, rd_val & m});
    endtask
    task automatic send(logic [15:0] f, logic [4:0] n);
        @(posedge clock);
        frame_bits <= f;
        frame_len <= n;
        frame_go <= 1'b1;
        @(posedge clock);
        frame_go <= 1'b0;
        cyc((n + 3) * BITC);
    endtask
    task automatic endt(string name);
        $display("test %s done", name);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog sized well past the expected run of under two thousand cycles
    initial begin
        #200000;
        failures++;
        report_and_stop;
    end

    initial begin
        clock = 1'b0; reset_n = 1'b0; clk_en = 1'b1; host_addr = 3'h0; addr_strobe_n = 1'b1;
        host_rd = 1'b0; host_wr = 1'b0; host_write_bus = 8'h00; modem_in_n = ulms_modem_t'(4'hf);
        frame_go = 1'b0; frame_bits = 16'hffff; frame_len = 5'h00; cap_len = 5'h0a;
        failures = 0; checks_done = 0;
        seed = $urandom(32'h03a729c7);
        cyc(8);
        reset_n <= 1'b1;
        cyc(3);
        rchk("line status reset", ADDR_LSR, 8'h60, 8'hff);
        rchk("scratch reset", ADDR_SCR, SCR_RST, 8'hff);
        bus(ADDR_MSR, 1'b0, 8'h00, rd_val);
        rchk("modem status idle", ADDR_MSR, 8'h00, 8'hff);
        bus(3'h1, 1'b1, 8'h5a, rd_val);
        rchk("unmapped read", 3'h1, 8'h00, 8'hff);
        for (int i = 0; i < 8; i++) begin
            wd = 8'($urandom);
            bus(ADDR_SCR, 1'b1, wd, rd_val);
            rchk("scratchpad", ADDR_SCR, wd, 8'hff);
        end
        // A write while the enable is low must leave the scratchpad alone
        clk_en <= 1'b0;
        bus(ADDR_SCR, 1'b1, ~wd, rd_val);
        clk_en <= 1'b1;
        rchk("scratch frozen", ADDR_SCR, wd, 8'hff);
        rchk("line status after scratch", ADDR_LSR, 8'h60, 8'hff);
        endt("registers");
        for (int i = 0; i < 8; i++) begin
            lc = {2'b00, 4'($urandom), 2'(i)};
            wd = 8'($urandom);
            bus(ADDR_LCTL, 1'b1, lc, rd_val);
            send(mkf(wd, lc, lc[3] & i[2], 1'b0), flen(lc));
            chk("data ready irq", 16'h1, {15'h0, irq.rx});
            chk("parity irq", {15'h0, lc[3] & i[2]}, {15'h0, irq.line});
            rchk("rx line status", ADDR_LSR, {5'h0, lc[3] & i[2], 2'b01}, 8'h1f);
            rchk("rx data", ADDR_DATA, wd & 8'((1 << (5 + lc[1:0])) - 1), 8'hff);
            rchk("rx status cleared", ADDR_LSR, 8'h00, 8'h1f);
        end
        bus(ADDR_LCTL, 1'b1, 8'h03, rd_val);
        wd = 8'($urandom);
        wd2 = 8'($urandom);
        send(mkf(wd, 8'h03, 1'b0, 1'b0), 5'd10);
        send(mkf(wd2, 8'h03, 1'b0, 1'b0), 5'd10);
        chk("overrun irq", 16'h1, {15'h0, irq.line});
        rchk("overrun", ADDR_LSR, 8'h03, 8'h1f);
        rchk("overrun data", ADDR_DATA, wd2, 8'hff);
        rchk("overrun cleared", ADDR_LSR, 8'h00, 8'h1f);
        send(mkf(wd, 8'h03, 1'b0, 1'b1), 5'd10);
        rchk("framing", ADDR_LSR, 8'h09, 8'h1f);
        rchk("framing data", ADDR_DATA, wd, 8'hff);
        send(16'h0000, 5'd16);
        // Let the trailing frame that the long low starts finish before reading
        cyc(12 * BITC);
        chk("break irq", 16'h1, {15'h0, irq.line});
        rchk("break", ADDR_LSR, 8'h10, 8'h10);
        bus(ADDR_DATA, 1'b0, 8'h00, rd_val);
        rchk("break cleared", ADDR_LSR, 8'h00, 8'h1f);
        endt("receive");
        for (int i = 0; i < 4; i++) begin
            lc = {2'b00, 4'($urandom), 2'(i)};
            wd = 8'($urandom);
            bus(ADDR_LCTL, 1'b1, lc, rd_val);
            cap_len <= 5'(7 + lc[1:0] + lc[3]);
            msk = 16'((17'h1 << (7 + lc[1:0] + lc[3])) - 1);
            c0 = cap_count;
            bus(ADDR_DATA, 1'b1, wd, rd_val);
            rchk("transmitter busy", ADDR_LSR, 8'h00, 8'h40);
            k = 0;
            while (cap_count === c0 && k < 400) begin
                cyc(1);
                k++;
            end
            if (k >= 400) chk("tx frame timeout", 16'h0, 16'h1);
            chk("tx frame", mkf(wd, lc, 1'b0, 1'b0) & msk, cap_frame & msk);
            cyc(3 * BITC);
            rchk("tx idle status", ADDR_LSR, 8'h60, 8'h60);
            chk("holding empty irq", 16'h1, {15'h0, irq.thr});
            bus(ADDR_IID, 1'b0, 8'h00, rd_val);
            rchk("holding empty cleared", ADDR_LSR, 8'h00, 8'h20);
        end
        endt("transmit");
        mo = 4'hf;
        for (int i = 0; i < 8; i++) begin
            mv = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
            @(posedge clock);
            modem_in_n <= ulms_modem_t'(mv);
            cyc(8);
            dl = {mo[3] ^ mv[3], ~mo[2] & mv[2], mo[1] ^ mv[1], mo[0] ^ mv[0]};
            chk("modem irq", {15'h0, |dl}, {15'h0, irq.modem});
            rchk("modem status", ADDR_MSR, {~mv, dl}, 8'hff);
            rchk("modem deltas cleared", ADDR_MSR, {~mv, 4'h0}, 8'hff);
            mo = mv;
        end
        endt("modem");
        bus(ADDR_MCTL, 1'b1, 8'h1f, rd_val);
        @(posedge clock);
        modem_in_n <= ulms_modem_t'(~mo);
        cyc(8);
        chk("loopback pins", 16'h1f, {11'h0, serial_output, dtr_n, rts_n, o1_n, o2_n});
        rchk("loopback levels on", ADDR_MSR, 8'hf0, 8'hf0);
        bus(ADDR_MCTL, 1'b1, 8'h10, rd_val);
        cyc(8);
        rchk("loopback levels off", ADDR_MSR, 8'h00, 8'hf0);
        bus(ADDR_MCTL, 1'b1, 8'h00, rd_val);
        endt("loopback");
        report_and_stop;
    end
endmodule
